// [src/cit_pkg.sv]
// cit_pkg: register offsets, field positions, reset values and codes for the
// comparator control and converter trigger selector.
// assumes an 8-bit processor data bus with byte addresses in data space.
package cit_pkg;

  // ---------------------------------------------------------------
  // register offsets (data space byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CMP_CTRL_STATUS_OFS = 8'h50; // comparator_control_status
  localparam logic [7:0] CONV_CTRL_B_OFS     = 8'h7b; // converter_control_b
  localparam logic [7:0] PIN_IN_DISABLE_OFS  = 8'h7f; // comparator_pin_input_disable

  // ---------------------------------------------------------------
  // comparator_control_status fields
  // ---------------------------------------------------------------
  localparam int CMP_DISABLE_BIT   = 7;
  localparam int BANDGAP_SEL_BIT   = 6;
  localparam int CMP_OUT_BIT       = 5;
  localparam int CMP_IRQ_FLAG_BIT  = 4;
  localparam int CMP_IRQ_EN_BIT    = 3;
  localparam int CMP_CAPTURE_BIT   = 2;
  localparam int CMP_IRQ_MODE_HI   = 1;
  localparam int CMP_IRQ_MODE_LO   = 0;

  // ---------------------------------------------------------------
  // converter_control_b fields
  // ---------------------------------------------------------------
  localparam int CMP_MUX_EN_BIT    = 6;
  localparam int TRIG_SRC_HI       = 2;
  localparam int TRIG_SRC_LO       = 0;

  // ---------------------------------------------------------------
  // comparator_pin_input_disable fields
  // ---------------------------------------------------------------
  localparam int NEG_PIN_OFF_BIT   = 1;
  localparam int POS_PIN_OFF_BIT   = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_B_RESET     = 8'h00;
  localparam logic [7:0] PIN_DIS_RESET    = 8'h00;
  localparam logic [1:0] IRQ_MODE_RESET   = 2'h0;
  localparam logic [2:0] TRIG_SRC_RESET   = 3'h0;
  localparam logic [2:0] CHAN_SEL_RESET   = 3'h0;

  // number of analog channels that may replace the negative input
  localparam int NUM_CHANNELS = 8;

  // ---------------------------------------------------------------
  // interrupt mode codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CIT_MODE_TOGGLE   = 2'b00,
    CIT_MODE_RESERVED = 2'b01,
    CIT_MODE_FALLING  = 2'b10,
    CIT_MODE_RISING   = 2'b11
  } cit_irq_mode_e;

  // ---------------------------------------------------------------
  // auto trigger source codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CIT_TRIG_FREE_RUN = 3'b000,
    CIT_TRIG_CMP      = 3'b001,
    CIT_TRIG_EXT_INT0 = 3'b010,
    CIT_TRIG_T0_CMPA  = 3'b011,
    CIT_TRIG_T0_OVF   = 3'b100,
    CIT_TRIG_T1_CMPB  = 3'b101,
    CIT_TRIG_T1_OVF   = 3'b110,
    CIT_TRIG_T1_CAPT  = 3'b111
  } cit_trig_src_e;

endpackage

// [src/cit_sync.sv]
// cit_sync: two flip-flop synchroniser for one asynchronous level.
// assumes the input comes from outside the core_clk domain.
`timescale 1ns/1ps
`default_nettype none

module cit_sync (
  input  wire logic core_clk,   // system clock
  input  wire logic reset_n,    // asynchronous reset, active low
  input  wire logic async_in,   // level from another domain
  output logic      sync_out    // level safe to use in core_clk domain
);

  logic stage1;                 // metastable stage, read only by stage two

  // ---------------------------------------------------------------
  // two stage capture
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

`default_nettype wire

// [src/cit_top.sv]
// cit_top: comparator control, negative/positive input select, output
// synchroniser, interrupt flag, capture routing, pin input disable and the
// converter auto trigger selector.
// assumes one-cycle bus strobes on core_clk, and analog select outputs that
// drive the analog switch network directly.
`timescale 1ns/1ps
`default_nettype none

module cit_top (
  input  wire logic       core_clk,             // system clock, 250 MHz
  input  wire logic       reset_n,              // asynchronous reset, active low
  // processor data bus
  input  wire logic [7:0] bus_addr,             // data space byte address
  input  wire logic [7:0] bus_wdata,            // write data
  input  wire logic       bus_wr,               // write strobe, one cycle
  input  wire logic       bus_rd,               // read strobe, one cycle
  output logic      [7:0] bus_rdata,            // read data, valid cycle after bus_rd
  // signals from neighbouring blocks (same clock)
  input  wire logic       converter_enable,     // converter switched on
  input  wire logic [2:0] channel_select,       // low bits of converter mux select
  input  wire logic       auto_trigger_enable,  // converter auto trigger on
  input  wire logic       conv_done_flag,       // converter completion flag
  input  wire logic       ext_int0_flag,        // external interrupt 0 flag
  input  wire logic       t0_cmpa_flag,         // timer0 compare A flag
  input  wire logic       t0_ovf_flag,          // timer0 overflow flag
  input  wire logic       t1_cmpb_flag,         // timer1 compare B flag
  input  wire logic       t1_ovf_flag,          // timer1 overflow flag
  input  wire logic       t1_capt_flag,         // timer1 capture flag
  input  wire logic       global_irq_enable,    // interrupt bit of cpu_status_word
  input  wire logic       cmp_irq_ack,          // vector taken, one cycle pulse
  // analog comparator and pins
  input  wire logic       cmp_raw_out,          // comparator output, asynchronous
  input  wire logic       pos_pin_raw,          // digital level of positive pin
  input  wire logic       neg_pin_raw,          // digital level of negative pin
  output logic            cmp_power_down,       // comparator power switch
  output logic            bandgap_to_pos,       // bandgap on positive input
  output logic            neg_from_channel,     // channel drives negative input
  output logic      [7:0] neg_channel_onehot,   // which channel drives it
  output logic            pos_pin_input_off,    // positive pin buffer off
  output logic            neg_pin_input_off,    // negative pin buffer off
  output logic            pos_pin_port_bit,     // port read value of positive pin
  output logic            neg_pin_port_bit,     // port read value of negative pin
  // outputs to timer and converter
  output logic            capture_input,        // to timer1 capture front end
  output logic            capture_from_cmp,     // capture source is comparator
  output logic            cmp_irq_req,          // comparator interrupt request
  output logic            conv_auto_start       // auto trigger start, one cycle
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic       cmp_disable;        // comparator power off
  logic       bandgap_select;     // bandgap on positive input
  logic       cmp_irq_flag;       // sticky interrupt flag
  logic       cmp_irq_enable;     // interrupt enable
  logic       cmp_capture_route;  // route output to timer capture
  logic [1:0] cmp_irq_mode;       // event selection
  logic       cmp_mux_enable;     // allow channel on negative input
  logic [2:0] auto_trigger_source;// trigger source code
  logic       pos_in_off;         // positive pin digital buffer off
  logic       neg_in_off;         // negative pin digital buffer off

  // ---------------------------------------------------------------
  // synchronised levels
  // ---------------------------------------------------------------
  logic cmp_output_status;        // synchronised comparator output
  logic cmp_prev;                 // previous synchronised sample
  logic pos_pin_sync;             // synchronised positive pin level
  logic neg_pin_sync;             // synchronised negative pin level

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic wr_csr;                   // write to comparator_control_status
  logic wr_ctrl_b;                // write to converter_control_b
  logic wr_pin_dis;               // write to comparator_pin_input_disable
  logic cmp_event;                // event matches selected mode
  logic trig_level;               // selected trigger flag level
  logic trig_prev;                // selected flag level one cycle earlier
  logic next_irq_flag;            // next value of interrupt flag
  logic [7:0] next_onehot;        // per-channel switch decode, registered below

  assign wr_csr     = bus_wr && (bus_addr == cit_pkg::CMP_CTRL_STATUS_OFS);
  assign wr_ctrl_b  = bus_wr && (bus_addr == cit_pkg::CONV_CTRL_B_OFS);
  assign wr_pin_dis = bus_wr && (bus_addr == cit_pkg::PIN_IN_DISABLE_OFS);

  for (genvar g = 0; g < cit_pkg::NUM_CHANNELS; g++) begin : g_chan
    assign next_onehot[g] = cmp_mux_enable && !converter_enable
                            && (channel_select == 3'(g));
  end

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  // comparator output goes high when positive input exceeds negative
  cit_sync u_sync_cmp (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (cmp_raw_out),
    .sync_out (cmp_output_status)  // two flops: one to two cycles latency
  );

  cit_sync u_sync_pos (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (pos_pin_raw),
    .sync_out (pos_pin_sync)
  );

  cit_sync u_sync_neg (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (neg_pin_raw),
    .sync_out (neg_pin_sync)
  );

  // ---------------------------------------------------------------
  // comparator control register
  // ---------------------------------------------------------------
  // software writes every writable bit; the flag is handled separately
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_disable       <= 1'b0;
      bandgap_select    <= 1'b0;
      cmp_irq_enable    <= 1'b0;
      cmp_capture_route <= 1'b0;
      cmp_irq_mode      <= cit_pkg::IRQ_MODE_RESET;
    end else if (wr_csr) begin
      cmp_disable       <= bus_wdata[cit_pkg::CMP_DISABLE_BIT];
      bandgap_select    <= bus_wdata[cit_pkg::BANDGAP_SEL_BIT];
      cmp_irq_enable    <= bus_wdata[cit_pkg::CMP_IRQ_EN_BIT];
      cmp_capture_route <= bus_wdata[cit_pkg::CMP_CAPTURE_BIT];
      cmp_irq_mode      <= bus_wdata[cit_pkg::CMP_IRQ_MODE_HI:cit_pkg::CMP_IRQ_MODE_LO];
    end
  end

  // ---------------------------------------------------------------
  // converter control b and pin input disable registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_mux_enable      <= cit_pkg::CTRL_B_RESET[cit_pkg::CMP_MUX_EN_BIT];
      auto_trigger_source <= cit_pkg::TRIG_SRC_RESET;
    end else if (wr_ctrl_b) begin
      cmp_mux_enable      <= bus_wdata[cit_pkg::CMP_MUX_EN_BIT];
      auto_trigger_source <= bus_wdata[cit_pkg::TRIG_SRC_HI:cit_pkg::TRIG_SRC_LO];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_in_off <= cit_pkg::PIN_DIS_RESET[cit_pkg::POS_PIN_OFF_BIT];
      neg_in_off <= cit_pkg::PIN_DIS_RESET[cit_pkg::NEG_PIN_OFF_BIT];
    end else if (wr_pin_dis) begin
      pos_in_off <= bus_wdata[cit_pkg::POS_PIN_OFF_BIT];
      neg_in_off <= bus_wdata[cit_pkg::NEG_PIN_OFF_BIT];
    end
  end

  // ---------------------------------------------------------------
  // event detection
  // ---------------------------------------------------------------
  // previous sample kept every cycle so edges span exactly one cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_prev <= 1'b0;
    end else begin
      cmp_prev <= cmp_output_status;
    end
  end

  // mode decode; the reserved code raises nothing
  always_comb begin
    cmp_event = 1'b0;
    case (cit_pkg::cit_irq_mode_e'(cmp_irq_mode))
      cit_pkg::CIT_MODE_TOGGLE:   cmp_event = cmp_output_status ^ cmp_prev;
      cit_pkg::CIT_MODE_FALLING:  cmp_event = cmp_prev && !cmp_output_status;
      cit_pkg::CIT_MODE_RISING:   cmp_event = !cmp_prev && cmp_output_status;
      cit_pkg::CIT_MODE_RESERVED: cmp_event = 1'b0;
      default:                    cmp_event = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // interrupt flag
  // ---------------------------------------------------------------
  // a new event wins over a clear in the same cycle so no edge is lost.
  // mode changes with the enable set cannot flag spuriously; an event needs
  // a real edge of the synchronised output, so the logic needs no guard
  always_comb begin
    next_irq_flag = cmp_irq_flag;
    if (cmp_irq_ack || (wr_csr && bus_wdata[cit_pkg::CMP_IRQ_FLAG_BIT])) begin
      next_irq_flag = 1'b0;
    end
    if (cmp_event) begin
      next_irq_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_irq_flag <= 1'b0;
    end else begin
      cmp_irq_flag <= next_irq_flag;
    end
  end

  // ---------------------------------------------------------------
  // auto trigger source selection
  // ---------------------------------------------------------------
  // the comparator source is its own interrupt flag
  always_comb begin
    trig_level = 1'b0;
    case (cit_pkg::cit_trig_src_e'(auto_trigger_source))
      cit_pkg::CIT_TRIG_FREE_RUN: trig_level = conv_done_flag;
      cit_pkg::CIT_TRIG_CMP:      trig_level = cmp_irq_flag;
      cit_pkg::CIT_TRIG_EXT_INT0: trig_level = ext_int0_flag;
      cit_pkg::CIT_TRIG_T0_CMPA:  trig_level = t0_cmpa_flag;
      cit_pkg::CIT_TRIG_T0_OVF:   trig_level = t0_ovf_flag;
      cit_pkg::CIT_TRIG_T1_CMPB:  trig_level = t1_cmpb_flag;
      cit_pkg::CIT_TRIG_T1_OVF:   trig_level = t1_ovf_flag;
      cit_pkg::CIT_TRIG_T1_CAPT:  trig_level = t1_capt_flag;
      default:                    trig_level = 1'b0;
    endcase
  end

  // the previous level is taken from the mux output, so a switch from a
  // cleared source to a set one looks like a rising edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_level;
    end
  end

  // start pulse; free running mode never pulses here, it is restarted by
  // the converter itself on completion, so switching to it is silent
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_auto_start <= 1'b0;
    end else begin
      conv_auto_start <= auto_trigger_enable && converter_enable
                         && (auto_trigger_source != cit_pkg::CIT_TRIG_FREE_RUN)
                         && trig_level && !trig_prev;
    end
  end

  // ---------------------------------------------------------------
  // analog steering and pin outputs
  // ---------------------------------------------------------------
  // registered so every output comes from a flop; one cycle of lag is
  // far below the analog settling time anyway
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_power_down     <= 1'b0;
      bandgap_to_pos     <= 1'b0;
      neg_from_channel   <= 1'b0;
      neg_channel_onehot <= 8'h00;
    end else begin
      cmp_power_down     <= cmp_disable;
      bandgap_to_pos     <= bandgap_select;
      neg_from_channel   <= cmp_mux_enable && !converter_enable;
      neg_channel_onehot <= next_onehot;
    end
  end

  // digital buffer off forces the port bit to zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_pin_input_off <= 1'b0;
      neg_pin_input_off <= 1'b0;
      pos_pin_port_bit  <= 1'b0;
      neg_pin_port_bit  <= 1'b0;
    end else begin
      pos_pin_input_off <= pos_in_off;
      neg_pin_input_off <= neg_in_off;
      pos_pin_port_bit  <= pos_pin_sync && !pos_in_off;
      neg_pin_port_bit  <= neg_pin_sync && !neg_in_off;
    end
  end

  // ---------------------------------------------------------------
  // capture routing and interrupt request
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_input    <= 1'b0;
      capture_from_cmp <= 1'b0;
      cmp_irq_req      <= 1'b0;
    end else begin
      capture_input    <= cmp_capture_route && cmp_output_status;
      capture_from_cmp <= cmp_capture_route;
      cmp_irq_req      <= next_irq_flag && cmp_irq_enable
                          && global_irq_enable && !cmp_irq_ack;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // unmapped addresses and unused bits read zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      case (bus_addr)
        cit_pkg::CMP_CTRL_STATUS_OFS: bus_rdata <= {cmp_disable, bandgap_select,
                                                    cmp_output_status, cmp_irq_flag,
                                                    cmp_irq_enable, cmp_capture_route,
                                                    cmp_irq_mode};
        cit_pkg::CONV_CTRL_B_OFS:     bus_rdata <= {1'b0, cmp_mux_enable, 3'h0,
                                                    auto_trigger_source};
        cit_pkg::PIN_IN_DISABLE_OFS:  bus_rdata <= {6'h00, neg_in_off, pos_in_off};
        default:                      bus_rdata <= 8'h00;
      endcase
    end else begin
      bus_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// [testbench/cit_monitor.sv]
// cit_monitor: port-level assertions on cit_top.
// assumes it is bound onto cit_top and shares its port names.
`timescale 1ns/1ps
`default_nettype none
module cit_monitor (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic       bus_wr,
  input wire logic       converter_enable,
  input wire logic [2:0] channel_select,
  input wire logic       auto_trigger_enable,
  input wire logic       global_irq_enable,
  input wire logic       cmp_irq_ack,
  input wire logic       cmp_raw_out,
  input wire logic       cmp_power_down,
  input wire logic       bandgap_to_pos,
  input wire logic       neg_from_channel,
  input wire logic [7:0] neg_channel_onehot,
  input wire logic       pos_pin_input_off,
  input wire logic       capture_input,
  input wire logic       capture_from_cmp,
  input wire logic       cmp_irq_req,
  input wire logic       conv_auto_start
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // a register write followed by two quiet cycles, so the copy has landed
  sequence s_quiet(logic [7:0] a);
    bus_wr && bus_addr == a ##1 !bus_wr [*2];
  endsequence
  a_neg_pin_forced: assert property (converter_enable |=> !neg_from_channel)
    else $error("negative input not on pin");
  a_chan_onehot: assert property (neg_channel_onehot ==
    (neg_from_channel ? 8'h01 << $past(channel_select) : 8'h00)) else $error("bad channel");
  a_auto_gated: assert property (!(auto_trigger_enable && converter_enable)
    |=> !conv_auto_start) else $error("start while gated");
  a_start_pulse: assert property (conv_auto_start |=> !conv_auto_start)
    else $error("start longer than a cycle");
  a_irq_global: assert property (!global_irq_enable [*2] |-> !cmp_irq_req)
    else $error("request without global enable");
  a_ack_clear: assert property ((cmp_raw_out == $past(cmp_raw_out)) [*4] ##0 cmp_irq_ack
    |=> !cmp_irq_req) else $error("request kept after ack");
  a_capture_sync: assert property ((capture_from_cmp && cmp_raw_out) [*4]
    |-> capture_input) else $error("capture path late");
  a_power_bandgap: assert property (s_quiet(cit_pkg::CMP_CTRL_STATUS_OFS) |->
    {cmp_power_down, bandgap_to_pos} == $past(bus_wdata[7:6], 2)) else $error("power bits");
  a_pin_off_copy: assert property (s_quiet(cit_pkg::PIN_IN_DISABLE_OFS) |->
    pos_pin_input_off == $past(bus_wdata[0], 2)) else $error("pin disable copy");
endmodule
bind cit_top cit_monitor u_mon (.*);
`default_nettype wire

// [testbench/cit_top_tb.sv]
// cit_top_tb: directed register-level tests of cit_top.
// assumes the monitor binds itself; one 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module cit_top_tb;
  logic       core_clk = 0, reset_n = 0, wr = 0, rd = 0, cen = 0, ate = 0, gie = 0;
  logic       ack = 0, raw = 0, pp = 0, np = 0, pd, bg, nfc, poff, noff, pport, nport;
  logic       cap, csrc, irq, start;
  logic [7:0] addr = 0, wdata = 0, rdata, d, flg = 0, oh;
  logic [2:0] chan = 0;
  logic [7:0] adrs [4] = '{8'h50, 8'h7b, 8'h7f, 8'h51};  // last one is unmapped
  int         fail_count = 0, checks = 0, n;
  always #2 core_clk = ~core_clk;
  cit_top dut (
    .core_clk(core_clk), .reset_n(reset_n), .bus_addr(addr), .bus_wdata(wdata),
    .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata), .converter_enable(cen),
    .channel_select(chan), .auto_trigger_enable(ate), .conv_done_flag(flg[0]),
    .ext_int0_flag(flg[2]), .t0_cmpa_flag(flg[3]), .t0_ovf_flag(flg[4]),
    .t1_cmpb_flag(flg[5]), .t1_ovf_flag(flg[6]), .t1_capt_flag(flg[7]),
    .global_irq_enable(gie), .cmp_irq_ack(ack), .cmp_raw_out(raw),
    .pos_pin_raw(pp), .neg_pin_raw(np), .cmp_power_down(pd), .bandgap_to_pos(bg),
    .neg_from_channel(nfc), .neg_channel_onehot(oh), .pos_pin_input_off(poff),
    .neg_pin_input_off(noff), .pos_pin_port_bit(pport), .neg_pin_port_bit(nport),
    .capture_input(cap), .capture_from_cmp(csrc), .cmp_irq_req(irq),
    .conv_auto_start(start));
  // waits k edges, then settles past the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // one-cycle write strobe
  task automatic bw(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk) {addr, wdata, wr} <= {a, v, 1'b1};
    @(posedge core_clk) wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic br(input logic [7:0] a);
    @(posedge core_clk) {addr, rd} <= {a, 1'b1};
    @(posedge core_clk) rd <= 1'b0;
    #1 d = rdata;
  endtask
  // counts start pulses over a short window
  task automatic starts(input int e);
    n = 0;
    repeat (6) begin
      @(posedge core_clk);
      #1 n += (start === 1'b1);
    end
    `CHECK("start count", e, n)
  endtask
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // the run needs a few hundred cycles; this is far beyond
  initial begin
    #20000;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (adrs[i]) begin
      br(adrs[i]);
      `CHECK("reset value", 8'h00, d)
    end
    bw(8'h7b, 8'hff);
    br(8'h7b);
    `CHECK("ctrl_b bits", 8'h47, d)
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk) chan <= 3'(i);
      cyc(3);
      `CHECK("channel onehot", 8'h01 << i, oh)
    end
    @(posedge core_clk) cen <= 1'b1;
    cyc(3);
    `CHECK("pin while conv on", 1'b0, nfc)
    @(posedge core_clk) ate <= 1'b1;
    for (int s = 2; s < 8; s++) begin
      bw(8'h7b, 8'(s));
      @(posedge core_clk) flg[s] <= 1'b1;
      starts(1);
      @(posedge core_clk) flg <= 8'h00;
    end
    @(posedge core_clk) {ate, flg} <= 9'h080;
    starts(0);
    @(posedge core_clk) {ate, flg} <= 9'h105;
    bw(8'h7b, 8'h00);
    starts(0);
    @(posedge core_clk) flg[0] <= 1'b0;  // free-run level low, so the switch is an edge
    bw(8'h7b, 8'h02);
    starts(1);
    bw(8'h7b, 8'h00);
    starts(0);
    for (int i = 0; i < 4; i++) begin
      bw(8'h50, {6'h04, 2'(i)});
      @(posedge core_clk) raw <= i[1];
      cyc(5);
      bw(8'h50, {6'h04, 2'(i)});
      @(posedge core_clk) raw <= ~i[1];
      cyc(5);
      br(8'h50);
      `CHECK("irq flag", ~i[0], d[4])
      `CHECK("cmp output", ~i[1], d[5])
      bw(8'h50, {6'h04, 2'(i)});
      br(8'h50);
      `CHECK("flag cleared", 1'b0, d[4])
    end
    bw(8'h7b, 8'h01);
    bw(8'h50, 8'h0b);
    @(posedge core_clk) raw <= 1'b1;
    starts(1);
    `CHECK("request masked", 1'b0, irq)
    @(posedge core_clk) gie <= 1'b1;
    cyc(2);
    `CHECK("request on", 1'b1, irq)
    bw(8'h50, 8'h03);
    cyc(2);
    `CHECK("request gated", 1'b0, irq)
    bw(8'h50, 8'h0b);
    @(posedge core_clk) ack <= 1'b1;
    @(posedge core_clk) ack <= 1'b0;
    cyc(2);
    `CHECK("request after ack", 1'b0, irq)
    bw(8'h50, 8'h03);
    bw(8'h50, 8'hc4);
    cyc(3);
    `CHECK("capture power gap", 4'hf, {cap, csrc, pd, bg})
    bw(8'h50, 8'h00);
    cyc(3);
    `CHECK("all off", 4'h0, {cap, csrc, pd, bg})
    @(posedge core_clk) {pp, np} <= 2'b11;
    cyc(3);
    `CHECK("port bits", 2'b11, {pport, nport})
    bw(8'h7f, 8'h03);
    cyc(3);
    `CHECK("pins off", 4'hc, {poff, noff, pport, nport})
    stop_test();
  end
endmodule
`default_nettype wire
